// ===== design/twpdc_pkg.sv
package twpdc_pkg;

  // Serial word shape
  localparam int unsigned WORD_BITS_MODE2 = 19;
  localparam int unsigned WORD_BITS_MODE1 = 18;
  localparam int unsigned PORT_BITS       = 4;
  localparam int unsigned DIV_BITS        = 15;
  localparam int unsigned PORT_LSB        = 0;
  localparam int unsigned DIV_LSB         = 4;
  localparam int unsigned DIV_MSB_MODE2   = 18;
  localparam int unsigned DIV_MSB_MODE1   = 17;

  // Reset values
  localparam logic [WORD_BITS_MODE2-1:0] SHIFT_RESET = 19'h00000;
  localparam logic [DIV_BITS-1:0]        DIV_RESET   = 15'h0000;
  localparam logic [PORT_BITS-1:0]       PORT_RESET  = 4'h0;

  // Frequencies in millihertz
  localparam longint unsigned XTAL_MILLIHZ  = 64'd4000000000;
  localparam longint unsigned COMP1_MILLIHZ = 64'd7812500;
  localparam longint unsigned COMP2_MILLIHZ = 64'd3906250;

  // Reference divider ratios, derived from the frequencies
  localparam int unsigned REF_BITS = 11;
  localparam logic [REF_BITS-1:0] REF_DIV_MODE1 =
    REF_BITS'(XTAL_MILLIHZ / COMP1_MILLIHZ);
  localparam logic [REF_BITS-1:0] REF_DIV_MODE2 =
    REF_BITS'(XTAL_MILLIHZ / COMP2_MILLIHZ);

  // Fixed RF prescaler
  localparam int unsigned PRE_BITS = 4;
  localparam logic [PRE_BITS-1:0] PRESCALE_DIV = 4'h8;

  // Lock detection timing
  localparam int unsigned MCLK_PERIOD_NS = 8;
  localparam int unsigned LOCK_WIN_NS    = 64;
  localparam int unsigned LOCK_WIN_CYC   = LOCK_WIN_NS / MCLK_PERIOD_NS;
  localparam int unsigned ERR_BITS       = 8;
  localparam logic [ERR_BITS-1:0] LOCK_WIN =
    ERR_BITS'(LOCK_WIN_CYC);
  localparam int unsigned GOOD_BITS      = 3;
  localparam logic [GOOD_BITS-1:0] LOCK_PERIODS = 3'h4;

endpackage

// ===== design/twpdc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module twpdc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // Asynchronous level in, synchronised level out
  input  wire logic [W-1:0] asyncIn,
  output var  logic [W-1:0] syncOut
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;

  // First stage is read only by the second
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= asyncIn;
      stage2_r <= stage1_r;
    end
  end

  assign syncOut = stage2_r;

endmodule // twpdc_sync

`default_nettype wire

// ===== design/twpdc_divider.sv
`timescale 1ns/1ps
`default_nettype none

module twpdc_divider #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // Input events and ratio
  input  wire logic         tick,
  input  wire logic [W-1:0] ratio,
  // One pulse every ratio ticks
  output var  logic         pulse
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         pulse_r;
  logic         pulse_nxt;

  // Ratio is sampled at each wrap, so a change takes effect cleanly
  always_comb begin
    cnt_nxt   = cnt_r;
    pulse_nxt = 1'b0;
    if (tick) begin
      if (cnt_r <= W'(1)) begin
        cnt_nxt   = ratio;
        pulse_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - W'(1);
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r   <= '0;
      pulse_r <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign pulse = pulse_r;

endmodule // twpdc_divider

`default_nettype wire

// ===== design/twpdc_top.sv
`timescale 1ns/1ps
`default_nettype none

module twpdc_top
  import twpdc_pkg::*;
(
  // Clocks and reset
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  input  wire logic                 serClk,
  // Three-wire bus, timed against serClk by the host
  input  wire logic                 serData,
  input  wire logic                 serEn,
  // Asynchronous pins
  input  wire logic                 modeSel,
  input  wire logic                 xtalIn,
  input  wire logic                 rfIn,
  // Loop outputs
  output var  logic                 dividedFeedbackFreq,
  output var  logic                 pumpUp,
  output var  logic                 pumpDown,
  // Open-drain lock flag
  output var  logic                 lockOut,
  output var  logic                 lockOe,
  // Open-collector ports
  output var  logic [PORT_BITS-1:0] openCollectorPortOutputs,
  output var  logic [PORT_BITS-1:0] openCollectorPortOutputsOe
);

  ////////////////////////////////////////////////////////////////////////
  // Serial clock domain: shift register

  logic [WORD_BITS_MODE2-1:0] shiftReg_r;
  logic [WORD_BITS_MODE2-1:0] shiftReg_nxt;

  // Enable and data meet setup and hold to serClk, so no synchroniser
  always_comb begin
    shiftReg_nxt = shiftReg_r;
    if (serEn) begin
      shiftReg_nxt = {shiftReg_r[WORD_BITS_MODE2-2:0], serData};
    end
  end

  always_ff @(posedge serClk or posedge sys_rst) begin
    if (sys_rst) begin
      shiftReg_r <= SHIFT_RESET;
    end else begin
      shiftReg_r <= shiftReg_nxt;
    end
  end

  a_shift_hold_low: assert property (
    @(posedge serClk) disable iff (sys_rst)
    !serEn |=> $stable(shiftReg_r))
    else $error("shift register moved with enable low");

  a_shift_bit_in: assert property (
    @(posedge serClk) disable iff (sys_rst)
    serEn |=> (shiftReg_r[0] == $past(serData))
      && (shiftReg_r[WORD_BITS_MODE2-1:1]
          == $past(shiftReg_r[WORD_BITS_MODE2-2:0])))
    else $error("serial bit not shifted in");

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers into mclk

  logic [3:0] pinSync;
  logic       enSync;
  logic       modeSync;
  logic       xtalSync;
  logic       rfSync;

  twpdc_sync #(
    .W (4)
  ) u_pin_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .asyncIn ({serEn, modeSel, xtalIn, rfIn}),
    .syncOut (pinSync)
  );

  assign enSync   = pinSync[3];
  assign modeSync = pinSync[2];
  assign xtalSync = pinSync[1];
  assign rfSync   = pinSync[0];

  ////////////////////////////////////////////////////////////////////////
  // Edge detection on synchronised levels

  logic enPrev_r;
  logic xtalPrev_r;
  logic rfPrev_r;
  logic loadPulse;
  logic xtalTick;
  logic rfTick;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      enPrev_r   <= 1'b0;
      xtalPrev_r <= 1'b0;
      rfPrev_r   <= 1'b0;
    end else begin
      enPrev_r   <= enSync;
      xtalPrev_r <= xtalSync;
      rfPrev_r   <= rfSync;
    end
  end

  assign loadPulse = enPrev_r & ~enSync;
  // RF sampled at mclk; only a slow test stimulus is resolved here
  assign xtalTick  = xtalSync & ~xtalPrev_r;
  assign rfTick    = rfSync & ~rfPrev_r;

  ////////////////////////////////////////////////////////////////////////
  // Data buffers, loaded at the falling edge of enable

  logic [DIV_BITS-1:0]  divisor_r;
  logic [DIV_BITS-1:0]  divisor_nxt;
  logic [PORT_BITS-1:0] portOe_r;
  logic [PORT_BITS-1:0] portOe_nxt;
  logic [DIV_BITS-1:0]  wordDivisor;

  // Shift register is quiet while enable is low, so the word is stable
  always_comb begin
    if (modeSync) begin
      wordDivisor = {1'b0, shiftReg_r[DIV_MSB_MODE1:DIV_LSB]};
    end else begin
      wordDivisor = shiftReg_r[DIV_MSB_MODE2:DIV_LSB];
    end
  end

  always_comb begin
    divisor_nxt = divisor_r;
    portOe_nxt  = portOe_r;
    if (loadPulse) begin
      divisor_nxt = wordDivisor;
      portOe_nxt  = shiftReg_r[PORT_LSB +: PORT_BITS];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      divisor_r <= DIV_RESET;
      portOe_r  <= PORT_RESET;
    end else begin
      divisor_r <= divisor_nxt;
      portOe_r  <= portOe_nxt;
    end
  end

  sequence s_enable_fall;
    enPrev_r && !enSync;
  endsequence

  a_load_on_fall: assert property (
    @(posedge mclk) disable iff (sys_rst)
    s_enable_fall |=> (divisor_r == $past(wordDivisor))
      && (portOe_r == $past(shiftReg_r[PORT_BITS-1:0])))
    else $error("buffers not loaded on enable fall");

  a_hold_no_fall: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !loadPulse |=> $stable(divisor_r) && $stable(portOe_r))
    else $error("buffers changed without enable fall");

  a_mode1_msb: assert property (
    @(posedge mclk) disable iff (sys_rst)
    s_enable_fall ##0 modeSync |=> (divisor_r[DIV_BITS-1] == 1'b0))
    else $error("mode 1 kept divisor top bit");

  ////////////////////////////////////////////////////////////////////////
  // Prescaler, programmable divider, reference divider

  logic                preTick;
  logic                fbPulse;
  logic                refPulse;
  logic [REF_BITS-1:0] refRatio;

  assign refRatio = modeSync ? REF_DIV_MODE1 : REF_DIV_MODE2;

  twpdc_divider #(
    .W (PRE_BITS)
  ) u_prescaler (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .tick    (rfTick),
    .ratio   (PRESCALE_DIV),
    .pulse   (preTick)
  );

  twpdc_divider #(
    .W (DIV_BITS)
  ) u_prog_div (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .tick    (preTick),
    .ratio   (divisor_r),
    .pulse   (fbPulse)
  );

  twpdc_divider #(
    .W (REF_BITS)
  ) u_ref_div (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .tick    (xtalTick),
    .ratio   (refRatio),
    .pulse   (refPulse)
  );

  a_ref_ratio: assert property (
    @(posedge mclk) disable iff (sys_rst)
    modeSync ? (refRatio == 11'h200) : (refRatio == 11'h400))
    else $error("reference ratio does not match mode");

  ////////////////////////////////////////////////////////////////////////
  // Phase and frequency comparator

  logic up_r;
  logic up_nxt;
  logic dn_r;
  logic dn_nxt;
  logic fb_r;

  // Both set means both edges seen: clear together, no dead zone state
  always_comb begin
    up_nxt = up_r | refPulse;
    dn_nxt = dn_r | fbPulse;
    if (up_r && dn_r) begin
      up_nxt = refPulse;
      dn_nxt = fbPulse;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      up_r <= 1'b0;
      dn_r <= 1'b0;
      fb_r <= 1'b0;
    end else begin
      up_r <= up_nxt;
      dn_r <= dn_nxt;
      fb_r <= fbPulse;
    end
  end

  a_pfd_clear: assert property (
    @(posedge mclk) disable iff (sys_rst)
    up_r && dn_r && !refPulse && !fbPulse |=> !up_r && !dn_r)
    else $error("comparator did not reset after both edges");

  a_pfd_ref_up: assert property (
    @(posedge mclk) disable iff (sys_rst)
    refPulse && !dn_r |=> up_r)
    else $error("reference edge did not raise pump up");

  ////////////////////////////////////////////////////////////////////////
  // Lock detector

  logic [ERR_BITS-1:0]  errCnt_r;
  logic [ERR_BITS-1:0]  errCnt_nxt;
  logic [GOOD_BITS-1:0] goodCnt_r;
  logic [GOOD_BITS-1:0] goodCnt_nxt;
  logic                 lockOe_r;
  logic                 lockOe_nxt;

  // Lock needs several consecutive periods with a narrow phase error
  always_comb begin
    errCnt_nxt  = errCnt_r;
    goodCnt_nxt = goodCnt_r;
    if ((up_r ^ dn_r) && (errCnt_r != {ERR_BITS{1'b1}})) begin
      errCnt_nxt = errCnt_r + ERR_BITS'(1);
    end
    if (refPulse) begin
      errCnt_nxt = '0;
      if (errCnt_r > LOCK_WIN) begin
        goodCnt_nxt = '0;
      end else if (goodCnt_r != LOCK_PERIODS) begin
        goodCnt_nxt = goodCnt_r + GOOD_BITS'(1);
      end
    end
    lockOe_nxt = (goodCnt_nxt == LOCK_PERIODS);
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      errCnt_r  <= '0;
      goodCnt_r <= '0;
      lockOe_r  <= 1'b0;
    end else begin
      errCnt_r  <= errCnt_nxt;
      goodCnt_r <= goodCnt_nxt;
      lockOe_r  <= lockOe_nxt;
    end
  end

  a_lock_flag: assert property (
    @(posedge mclk) disable iff (sys_rst)
    lockOe_r == (goodCnt_r == LOCK_PERIODS))
    else $error("lock flag disagrees with lock count");

  a_lock_loss: assert property (
    @(posedge mclk) disable iff (sys_rst)
    refPulse && (errCnt_r > LOCK_WIN) |=> !lockOe_r)
    else $error("lock flag kept after wide phase error");

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign dividedFeedbackFreq        = fb_r;
  assign pumpUp                     = up_r;
  assign pumpDown                   = dn_r;
  // Open drain: only ever pulls low, released when out of lock
  assign lockOut                    = 1'b0;
  assign lockOe                     = lockOe_r;
  assign openCollectorPortOutputs   = PORT_RESET;
  assign openCollectorPortOutputsOe = portOe_r;

  a_port_follow: assert property (
    @(posedge mclk) disable iff (sys_rst)
    loadPulse ##1 !loadPulse [*2] |-> openCollectorPortOutputsOe
      == $past(shiftReg_r[PORT_BITS-1:0], 2))
    else $error("port enables do not follow loaded bits");

endmodule // twpdc_top

`default_nettype wire

// ===== tb/twpdc_host.sv
`timescale 1ns/1ps
`default_nettype none

module twpdc_host (
  // Three-wire bus towards the device
  output var logic serClk,
  output var logic serData,
  output var logic serEn
);
  initial begin
    serClk  = 1'b0;
    serData = 1'b0;
    serEn   = 1'b0;
  end

  // Clock stands still between frames; 5 ns skew keeps it off mclk edges
  task automatic sendWord(input logic [31:0] word, input int nBits,
                          input bit drop);
    #5;
    serEn = 1'b1;
    #16;
    for (int i = nBits - 1; i >= 0; i--) begin
      serData = word[i];
      #16 serClk = 1'b1;
      #16 serClk = 1'b0;
    end
    if (drop) begin
      endFrame();
    end
  endtask

  task automatic endFrame();
    #16 serEn = 1'b0;
    // Hold time over, so the line no longer shows the last bit
    #16 serData = ~serData;
  endtask

  task automatic strayClocks(input int n);
    #5;
    repeat (n) begin
      serData = ~serData;
      #16 serClk = 1'b1;
      #16 serClk = 1'b0;
    end
  endtask
endmodule // twpdc_host

`default_nettype wire

// ===== tb/three_wire_pll_divider_control_test.sv
`timescale 1ns/1ps
`default_nettype none

module three_wire_pll_divider_control_test;
  import twpdc_pkg::*;

  logic                 mclk    = 1'b0;
  logic                 sys_rst = 1'b1;
  logic                 modeSel = 1'b0;
  logic                 xtalIn  = 1'b0;
  logic                 rfIn    = 1'b0;
  logic                 serClk, serData, serEn;
  logic                 fbOut, pumpUp, pumpDown, lockOut, lockOe;
  logic [PORT_BITS-1:0] ports, portsOe, oldPorts;
  logic                 xtalRun = 1'b0;
  logic                 rfRun   = 1'b0;
  logic                 prevUp  = 1'b0;
  logic [31:0]          w;
  int                   failures = 0;
  int                   checked  = 0;
  int                   ph = 0;
  int                   xtalRises = 0;
  int                   rfRises = 0;
  int                   upAt[$];
  int                   fbAt[$];
  logic [18:0]          fbWord [3] = '{19'h40035, 19'h00055, 19'h00000};
  bit                   fbMode [3] = '{1'b1, 1'b0, 1'b1};

  always #4 mclk = ~mclk;

  twpdc_host u_twpdc_host (.serClk(serClk), .serData(serData),
                           .serEn(serEn));

  twpdc_top u_twpdc_top (
    .mclk(mclk), .sys_rst(sys_rst), .serClk(serClk),
    .serData(serData), .serEn(serEn), .modeSel(modeSel),
    .xtalIn(xtalIn), .rfIn(rfIn), .dividedFeedbackFreq(fbOut),
    .pumpUp(pumpUp), .pumpDown(pumpDown), .lockOut(lockOut),
    .lockOe(lockOe), .openCollectorPortOutputs(ports),
    .openCollectorPortOutputsOe(portsOe));

  ////////////////////////////////////////////////////////////////////
  // Crystal and RF sources, period of 4 mclk cycles each
  always @(posedge mclk) begin
    ph <= (ph + 1) % 4;
    if (xtalRun && ph == 1) begin
      xtalIn    <= 1'b1;
      xtalRises <= xtalRises + 1;
    end
    if (rfRun && ph == 1) begin
      rfIn    <= 1'b1;
      rfRises <= rfRises + 1;
    end
    if (ph == 3) begin
      xtalIn <= 1'b0;
      rfIn   <= 1'b0;
    end
    prevUp <= pumpUp;
    if (pumpUp === 1'b1 && prevUp === 1'b0) upAt.push_back(xtalRises);
    if (fbOut === 1'b1) fbAt.push_back(rfRises);
  end

  ////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checked %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  function automatic int expFbGap(input logic [18:0] wd, input bit m1);
    logic [14:0] d;
    d = m1 ? {1'b0, wd[17:4]} : wd[18:4];
    return 8 * ((d < 2) ? 1 : d);
  endfunction

  function automatic int expRefGap(input bit m1);
    return m1 ? 512 : 1024;
  endfunction

  task automatic load(input logic [18:0] wd, input int n, input bit m);
    @(posedge mclk);
    modeSel <= m;
    repeat (4) @(posedge mclk);
    u_twpdc_host.sendWord(32'(wd), n, 1'b1);
    repeat (8) @(posedge mclk);
  endtask

  task automatic waitQ(input bit up, input int n);
    for (int i = 0; i < 16000; i++) begin
      if ((up ? upAt.size() : fbAt.size()) >= n) break;
      @(posedge mclk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h2096));
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    check("outputs at reset", {fbOut, pumpUp, pumpDown, lockOut, lockOe,
          ports, portsOe}, 32'h0);
    oldPorts = PORT_RESET;
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 32'h7ffff : $urandom;
      @(posedge mclk);
      modeSel <= i[0];
      repeat (4) @(posedge mclk);
      u_twpdc_host.sendWord(w, i[0] ? 18 : 19, 1'b0);
      repeat (8) @(posedge mclk);
      check("ports before enable falls", portsOe, oldPorts);
      u_twpdc_host.endFrame();
      repeat (8) @(posedge mclk);
      check("ports after load", portsOe, w[3:0]);
      check("port pin level", ports, 4'h0);
      oldPorts = w[3:0];
    end
    // Clocks with enable low, then an empty frame reloads the buffers
    u_twpdc_host.strayClocks(7);
    u_twpdc_host.sendWord(32'h0, 0, 1'b1);
    repeat (8) @(posedge mclk);
    check("ports after stray clocks", portsOe, oldPorts);
    for (int k = 0; k < 3; k++) begin
      load(fbWord[k], 19, fbMode[k]);
      fbAt.delete();
      rfRun <= 1'b1;
      waitQ(1'b0, 3);
      rfRun <= 1'b0;
      check("feedback pulses", fbAt.size() >= 3, 1);
      check("feedback gap", fbAt[2] - fbAt[1],
            expFbGap(fbWord[k], fbMode[k]));
    end
    for (int m = 1; m >= 0; m--) begin
      load(19'h00000, m ? 18 : 19, m[0]);
      upAt.delete();
      rfRun   <= 1'b1;
      xtalRun <= 1'b1;
      waitQ(1'b1, 3);
      check("reference gap", upAt[2] - upAt[1],
            expRefGap(m[0]));
      check("lock released", {lockOe, lockOut}, 2'b00);
    end
    // Feedback stops: reference leads and the up pump stays on
    rfRun <= 1'b0;
    upAt.delete();
    waitQ(1'b1, 2);
    repeat (20) @(posedge mclk);
    check("pumps without feedback", {pumpUp, pumpDown}, 2'b10);
    check("lock without feedback", lockOe, 1'b0);
    // Second reset zeroes all counters, so matched rates line up and lock
    rfRun   <= 1'b0;
    xtalRun <= 1'b0;
    sys_rst <= 1'b1;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    check("outputs after reset", {fbOut, pumpUp, pumpDown, lockOut, lockOe,
          ports, portsOe}, 32'h0);
    load(19'h0040a, 18, 1'b1);
    check("ports after reset load", portsOe, 4'ha);
    upAt.delete();
    rfRun   <= 1'b1;
    xtalRun <= 1'b1;
    waitQ(1'b1, 4);
    repeat (4) @(posedge mclk);
    check("lock flag", {lockOe, lockOut}, 2'b10);
    // Feedback gone: lock holds one period, drops at the next
    rfRun <= 1'b0;
    repeat (4300) @(posedge mclk);
    check("lock lost", lockOe, 1'b0);
    stop_test();
  end

  initial begin
    repeat (90000) @(posedge mclk);
    failures++;
    stop_test();
  end
endmodule // three_wire_pll_divider_control_test

`default_nettype wire
